//--- bench/tb_top.sv
`default_nettype none
`define CHK(n, e, g) check(n, 96'(e), 96'(g))
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ser_clk, ser_in, ser_out, link_gate_n;
  logic update_n, mode_sel, matrix_rst_n, addr_match_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, chip_addr_pins;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] overlay_select, out_gain_x2, out_enable, out_fill_sel, eg, ee;
  logic [63:0] out_route_sel, er;
  logic [95:0] d1;
  int n_errors = 0;
  int n_tests = 0;
  xpc_serial_ctrl u_xpc_serial_ctrl (.aclk, .aresetn, .clk_en, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .ser_clk, .ser_in, .ser_out,
    .link_gate_n, .update_n, .mode_sel, .matrix_rst_n, .chip_addr_pins,
    .overlay_select, .addr_match_n, .out_route_sel, .out_gain_x2, .out_enable,
    .out_fill_sel);
  xpc_host_model u_host (.aclk, .ser_clk, .ser_in, .link_gate_n, .update_n);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task check(input string nm, input logic [95:0] e, input logic [95:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task timeout;
    n_errors++;
    $display("MISMATCH bus_wait expected answer seen none");
    end_of_test();
  endtask
  task wr(input logic [7:0] a, input logic [31:0] dt);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (i == 100) timeout();
  endtask
  task rdr(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (i == 100) timeout();
  endtask
  task set_exp(input logic [95:0] d);
    for (int k = 0; k < 16; k++) begin
      er[4*k+:4] = d[6*k+:4];
      eg[k] = d[6*k+4];
      ee[k] = d[6*k+5];
    end
  endtask
  task chk_mat;
    `CHK("route", er, out_route_sel);
    `CHK("gain", eg, out_gain_x2);
    `CHK("enable", ee, out_enable);
  endtask
  task t_reset;
    `CHK("enable_init", 16'h0, out_enable);
    `CHK("match_init", 1'b1, addr_match_n);
    $display("done reset");
  endtask
  task t_mode1;
    for (int k = 0; k < 16; k++) d1[6*k+:6] = 6'(k * 11 + 5);
    set_exp(d1);
    @(posedge aclk);
    mode_sel <= 1'b1;
    u_host.shift(d1, 96, 1'b1);
    `CHK("chain_out", d1[95], ser_out);
    u_host.commit(1'b1);
    chk_mat();
    $display("done mode1");
  endtask
  task t_mode0(input logic [3:0] chip, input logic hit);
    logic [15:0] w;
    w = {2'b11, chip, 4'h3, 2'b11, chip ^ 4'hc};
    @(posedge aclk);
    mode_sel <= 1'b0;
    if (hit) begin
      er[15:12] = chip ^ 4'hc;
      eg[3] = 1'b1;
      ee[3] = 1'b1;
    end
    u_host.shift(96'({4'ha, w}), 20, 1'b1);
    idle(4);
    `CHK("pass", u_host.ser_in, ser_out);
    fork
      u_host.commit(1'b1);
      begin
        idle(12);
        `CHK("match_n", !hit, addr_match_n);
      end
    join
    idle(6);
    `CHK("match_n_idle", 1'b1, addr_match_n);
    chk_mat();
    $display("done mode0");
  endtask
  task t_gate;
    @(posedge aclk);
    mode_sel <= 1'b1;
    u_host.shift('1, 96, 1'b0);
    u_host.commit(1'b0);
    chk_mat();
    $display("done gate");
  endtask
  task t_regs;
    rdr(xpc_pkg::REG_CTRL);
    `CHK("ctrl_rst", 32'h1, rd);
    rdr(xpc_pkg::REG_ENGAIN);
    `CHK("engain", {eg, ee}, rd);
    rdr(xpc_pkg::REG_ROUTE_LO);
    `CHK("route_lo", er[31:0], rd);
    rdr(xpc_pkg::REG_ROUTE_HI);
    `CHK("route_hi", er[63:32], rd);
    rdr(xpc_pkg::REG_STATUS);
    `CHK("status_mode", 3'h1, rd[2:0]);
    `CHK("status_word", 16'hd8fa, rd[31:16]);
    rdr(8'h40);
    `CHK("rresp_bad", xpc_pkg::RESP_SLVERR, rs);
    `CHK("rdata_bad", 32'h0, rd);
    wr(8'h40, 32'h1);
    `CHK("bresp_bad", xpc_pkg::RESP_SLVERR, rs);
    wr(xpc_pkg::REG_CTRL, 32'h0);
    `CHK("bresp_ctrl", xpc_pkg::RESP_OKAY, rs);
    rdr(xpc_pkg::REG_CTRL);
    `CHK("ctrl_off", 32'h0, rd);
    u_host.shift(~d1, 96, 1'b1);
    u_host.commit(1'b1);
    chk_mat();
    wr(xpc_pkg::REG_CTRL, 32'h1);
    `CHK("bresp_on", xpc_pkg::RESP_OKAY, rs);
    $display("done regs");
  endtask
  task t_overlay;
    @(posedge aclk);
    overlay_select <= 16'h5a3c;
    idle(4);
    `CHK("fill_sel", 16'ha5c3, out_fill_sel);
    clk_en <= 1'b0;
    overlay_select <= 16'h00ff;
    idle(4);
    `CHK("fill_frozen", 16'ha5c3, out_fill_sel);
    clk_en <= 1'b1;
    idle(4);
    `CHK("fill_sel_back", 16'hff00, out_fill_sel);
    $display("done overlay");
  endtask
  task t_mrst;
    @(posedge aclk);
    matrix_rst_n <= 1'b0;
    idle(6);
    `CHK("enable_rst", 16'h0, out_enable);
    `CHK("route_rst", 64'h0, out_route_sel);
    @(posedge aclk);
    matrix_rst_n <= 1'b1;
    idle(4);
    set_exp(d1);
    u_host.commit(1'b1);
    chk_mat();
    $display("done matrix reset");
  endtask
  initial begin
    clk_en = 1'b1;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    mode_sel = 1'b1;
    matrix_rst_n = 1'b1;
    chip_addr_pins = 4'h5;
    overlay_select = 16'hffff;
    idle(10);
    aresetn <= 1'b1;
    idle(4);
    t_reset();
    t_mode1();
    t_mode0(4'h5, 1'b1);
    t_mode0(4'h6, 1'b0);
    t_gate();
    t_regs();
    t_overlay();
    t_mrst();
    end_of_test();
  end
endmodule
`default_nettype wire

//--- bench/xpc_host_model.sv
`default_nettype none
module xpc_host_model (
  input wire logic aclk,
  output logic ser_clk,
  output logic ser_in,
  output logic link_gate_n,
  output logic update_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ser_clk = 1'b1;
    ser_in = 1'b0;
    link_gate_n = 1'b1;
    update_n = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // clock idles high outside frames, 4 cycles low and 4 high
  // released data line is inverted
  task automatic shift(input logic [95:0] d, input int n, input logic open);
    @(posedge aclk);
    link_gate_n <= !open;
    wait_clk(4);
    for (int i = n - 1; i >= 0; i--) begin
      ser_in <= d[i];
      wait_clk(4);
      ser_clk <= 1'b0;
      wait_clk(4);
      ser_clk <= 1'b1;
    end
    ser_in <= !ser_in;
    wait_clk(4);
    link_gate_n <= 1'b1;
  endtask
  task automatic commit(input logic open);
    @(posedge aclk);
    link_gate_n <= !open;
    wait_clk(4);
    update_n <= 1'b0;
    wait_clk(20);
    update_n <= 1'b1;
    wait_clk(4);
    link_gate_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- logic/xpc_chain.sv
`default_nettype none
module xpc_chain #(
  parameter int LEN = 96
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic shift_en,
  input wire logic bit_in,
  output logic [LEN-1:0] chain
);
  if (LEN < 2) begin : g_chk
    $error("xpc_chain: LEN must be at least 2");
  end

  logic [LEN-1:0] chain_ff;
  logic [LEN-1:0] nxt_chain;

  // new bit enters at the bottom, oldest leaves at the top
  assign nxt_chain = {chain_ff[LEN-2:0], bit_in};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chain_ff <= '0;
    end else if (clk_en && shift_en) begin
      chain_ff <= nxt_chain;
    end
  end

  assign chain = chain_ff;
endmodule
`default_nettype wire

//--- logic/xpc_pkg.sv
`default_nettype none
package xpc_pkg;
  // matrix geometry
  localparam int NUM_OUT = 16;
  localparam int SEL_W = 4;
  localparam int FIELD_W = 6;
  localparam int WORD_W = 16;
  localparam int CHIP_W = 4;
  localparam int OUT_AW = 4;
  // control field and word layout
  localparam int F_SEL_LSB = 0;
  localparam int F_GAIN = 4;
  localparam int F_EN = 5;
  localparam int W_OUT_LSB = 6;
  localparam int W_CHIP_LSB = 10;
  localparam logic [5:0] FIELD_RST = 6'h00;
  // synchroniser bit positions
  localparam int P_OVL_LSB = 0;
  localparam int P_CHIP_LSB = 16;
  localparam int P_SCLK = 20;
  localparam int P_DIN = 21;
  localparam int P_GATE = 22;
  localparam int P_UPD = 23;
  localparam int P_MODE = 24;
  localparam int P_MRST = 25;
  localparam int SYNC_W = 26;
  // register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ENGAIN = 8'h08;
  localparam logic [7:0] REG_ROUTE_LO = 8'h0c;
  localparam logic [7:0] REG_ROUTE_HI = 8'h10;
  localparam int CTRL_LINK_EN = 0;
  localparam logic CTRL_LINK_EN_RST = 1'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- logic/xpc_serial_ctrl.sv
`default_nettype none
module xpc_serial_ctrl #(
  parameter int NUM_OUT = xpc_pkg::NUM_OUT,
  parameter int ADDR_W = xpc_pkg::ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ser_clk,
  input wire logic ser_in,
  output logic ser_out,
  input wire logic link_gate_n,
  input wire logic update_n,
  input wire logic mode_sel,
  input wire logic matrix_rst_n,
  input wire logic [3:0] chip_addr_pins,
  input wire logic [15:0] overlay_select,
  output logic addr_match_n,
  output logic [4*NUM_OUT-1:0] out_route_sel,
  output logic [NUM_OUT-1:0] out_gain_x2,
  output logic [NUM_OUT-1:0] out_enable,
  output logic [NUM_OUT-1:0] out_fill_sel
);
  localparam int FW = xpc_pkg::FIELD_W;
  localparam int CFG_W = NUM_OUT * FW;
  localparam int DW = xpc_pkg::DATA_W;

  if (NUM_OUT != 16) begin : g_chk_out
    $error("xpc_serial_ctrl: NUM_OUT must be 16");
  end
  if (ADDR_W != xpc_pkg::ADDR_W) begin : g_chk_addr
    $error("xpc_serial_ctrl: ADDR_W must match the register map");
  end

  function automatic logic [5:0] field_of(input logic [CFG_W-1:0] v, input int k);
    return v[k*FW +: FW];
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return a == xpc_pkg::REG_CTRL || a == xpc_pkg::REG_STATUS ||
      a == xpc_pkg::REG_ENGAIN || a == xpc_pkg::REG_ROUTE_LO ||
      a == xpc_pkg::REG_ROUTE_HI;
  endfunction

  // pin synchronisers
  logic [xpc_pkg::SYNC_W-1:0] pins_s;
  xpc_sync #(
    .W(xpc_pkg::SYNC_W),
    .RST_VAL({xpc_pkg::SYNC_W{1'h1}})
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .d_in({matrix_rst_n, mode_sel, update_n, link_gate_n, ser_in, ser_clk,
      chip_addr_pins, overlay_select}),
    .d_out(pins_s)
  );

  wire [15:0] ovl_s = pins_s[xpc_pkg::P_OVL_LSB +: NUM_OUT];
  wire [3:0] chip_s = pins_s[xpc_pkg::P_CHIP_LSB +: xpc_pkg::CHIP_W];
  wire sclk_s = pins_s[xpc_pkg::P_SCLK];
  wire din_s = pins_s[xpc_pkg::P_DIN];
  wire gate_n_s = pins_s[xpc_pkg::P_GATE];
  wire upd_s = pins_s[xpc_pkg::P_UPD];
  wire mode_s = pins_s[xpc_pkg::P_MODE];
  wire mrst_n_s = pins_s[xpc_pkg::P_MRST];

  logic sclk_prev_ff;
  logic upd_prev_ff;
  logic link_en_ff;
  logic [15:0] m0_word_ff;
  logic [CFG_W-1:0] cfg_ff;
  logic [CFG_W-1:0] nxt_cfg;
  logic [CFG_W-1:0] chain_w;
  logic ser_out_ff;
  logic addr_match_n_ff;
  logic [NUM_OUT-1:0] fill_sel_ff;

  // event decode
  wire active = ~gate_n_s & link_en_ff;
  wire sclk_fall = sclk_prev_ff & ~sclk_s;
  wire upd_fall = upd_prev_ff & ~upd_s;
  wire rst_act = ~mrst_n_s;
  wire chip_hit = m0_word_ff[xpc_pkg::W_CHIP_LSB +: xpc_pkg::CHIP_W] == chip_s;
  wire m1_shift = active & mode_s & upd_s & sclk_fall;
  wire m0_shift = active & ~mode_s & upd_s & sclk_fall;
  wire load_all = active & mode_s & upd_fall;
  wire load_one = active & ~mode_s & upd_fall & chip_hit;
  wire [15:0] nxt_m0_word = {m0_word_ff[14:0], din_s};

  // 96-bit matrix chain
  xpc_chain #(
    .LEN(CFG_W)
  ) u_chain (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .shift_en(m1_shift),
    .bit_in(din_s),
    .chain(chain_w)
  );

  // per-output latches
  for (genvar k = 0; k < NUM_OUT; k++) begin : g_out
    wire [5:0] m1_fld = field_of(chain_w, k);
    wire [5:0] cur_fld = field_of(cfg_ff, k);
    wire pick = m0_word_ff[xpc_pkg::W_OUT_LSB +: xpc_pkg::OUT_AW] == 4'(k);
    assign nxt_cfg[k*FW +: FW] = rst_act ? xpc_pkg::FIELD_RST :
      load_all ? m1_fld :
      (load_one && pick) ? m0_word_ff[FW-1:0] : cur_fld;
    assign out_route_sel[k*4 +: 4] = cfg_ff[k*FW + xpc_pkg::F_SEL_LSB +: xpc_pkg::SEL_W];
    assign out_gain_x2[k] = cfg_ff[k*FW + xpc_pkg::F_GAIN];
    assign out_enable[k] = cfg_ff[k*FW + xpc_pkg::F_EN];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_prev_ff <= 1'h1;
      upd_prev_ff <= 1'h1;
      m0_word_ff <= 16'h0000;
      cfg_ff <= '0;
      ser_out_ff <= 1'h0;
      addr_match_n_ff <= 1'h1;
      fill_sel_ff <= '0;
    end else if (clk_en) begin
      sclk_prev_ff <= sclk_s;
      upd_prev_ff <= upd_s;
      if (m0_shift) begin
        m0_word_ff <= nxt_m0_word;
      end
      cfg_ff <= nxt_cfg;
      ser_out_ff <= mode_s ? chain_w[CFG_W-1] : din_s;
      addr_match_n_ff <= ~(active & ~mode_s & ~upd_s & chip_hit);
      fill_sel_ff <= ~ovl_s;
    end
  end

  assign ser_out = ser_out_ff;
  assign addr_match_n = addr_match_n_ff;
  assign out_fill_sel = fill_sel_ff;

  // register bus, write side
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic w_strb0_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;

  wire aw_take = awvalid & awready_ff;
  wire w_take = wvalid & wready_ff;
  wire do_wr = aw_hold_ff & w_hold_ff;
  wire b_done = bvalid_ff & bready;
  wire ctrl_wr = do_wr & (aw_addr_ff == xpc_pkg::REG_CTRL) & w_strb0_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'h0;
      w_hold_ff <= 1'h0;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h0000_0000;
      w_strb0_ff <= 1'h0;
      awready_ff <= 1'h1;
      wready_ff <= 1'h1;
      bvalid_ff <= 1'h0;
      bresp_ff <= xpc_pkg::RESP_OKAY;
      link_en_ff <= xpc_pkg::CTRL_LINK_EN_RST;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_hold_ff <= 1'h1;
        aw_addr_ff <= awaddr;
        awready_ff <= 1'h0;
      end
      if (w_take) begin
        w_hold_ff <= 1'h1;
        w_data_ff <= wdata;
        w_strb0_ff <= wstrb[0];
        wready_ff <= 1'h0;
      end
      if (do_wr) begin
        aw_hold_ff <= 1'h0;
        w_hold_ff <= 1'h0;
        bvalid_ff <= 1'h1;
        bresp_ff <= addr_ok(aw_addr_ff) ? xpc_pkg::RESP_OKAY : xpc_pkg::RESP_SLVERR;
      end
      if (ctrl_wr) begin
        link_en_ff <= w_data_ff[xpc_pkg::CTRL_LINK_EN];
      end
      if (b_done) begin
        bvalid_ff <= 1'h0;
        awready_ff <= 1'h1;
        wready_ff <= 1'h1;
      end
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // register bus, read side
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  wire ar_take = arvalid & arready_ff;
  wire [31:0] rd_ctrl = {31'h0000_0000, link_en_ff};
  wire [31:0] rd_stat = {m0_word_ff, 13'h0000, ~addr_match_n_ff, active, mode_s};
  wire [31:0] rd_engain = {out_gain_x2, out_enable};
  wire [31:0] rd_route_lo = out_route_sel[0 +: DW];
  wire [31:0] rd_route_hi = out_route_sel[DW +: DW];
  wire [31:0] rd_mux = (araddr == xpc_pkg::REG_CTRL) ? rd_ctrl :
    (araddr == xpc_pkg::REG_STATUS) ? rd_stat :
    (araddr == xpc_pkg::REG_ENGAIN) ? rd_engain :
    (araddr == xpc_pkg::REG_ROUTE_LO) ? rd_route_lo :
    (araddr == xpc_pkg::REG_ROUTE_HI) ? rd_route_hi : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'h1;
      rvalid_ff <= 1'h0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= xpc_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (ar_take) begin
        arready_ff <= 1'h0;
        rvalid_ff <= 1'h1;
        rdata_ff <= rd_mux;
        rresp_ff <= addr_ok(araddr) ? xpc_pkg::RESP_OKAY : xpc_pkg::RESP_SLVERR;
      end else if (rvalid_ff && rready) begin
        rvalid_ff <= 1'h0;
        arready_ff <= 1'h1;
      end
    end
  end

  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  rst_disable_a: assert property (
    clk_en && rst_act |=> out_enable == '0 && out_route_sel == '0)
    else $error("reset pin did not clear the matrix");

  rst_keep_a: assert property (
    clk_en && rst_act && !m0_shift && !m1_shift |=> $stable(m0_word_ff) && $stable(chain_w))
    else $error("reset pin disturbed shift registers");

  gate_idle_a: assert property (
    clk_en && !active && !rst_act |=> $stable(cfg_ff) && $stable(m0_word_ff))
    else $error("logic changed with gate closed");

  chain_load_a: assert property (
    clk_en && load_all && !rst_act |=> cfg_ff == $past(chain_w))
    else $error("matrix load did not copy chain");

  chain_out_a: assert property (
    clk_en && m1_shift ##1 clk_en && mode_s |=> ser_out == $past(chain_w[CFG_W-2], 2))
    else $error("chain output bit out of step");

  pass_thru_a: assert property (
    clk_en && !mode_s |=> ser_out == $past(din_s))
    else $error("mode 0 serial output not passing input");

  word_shift_a: assert property (
    clk_en && m0_shift |=> m0_word_ff == $past(nxt_m0_word))
    else $error("mode 0 word did not shift");

  match_out_a: assert property (
    clk_en && active && !mode_s && !upd_s && chip_hit |=> !addr_match_n)
    else $error("address match output not low");

  miss_keep_a: assert property (
    clk_en && upd_fall && !mode_s && !chip_hit && !rst_act |=> $stable(cfg_ff))
    else $error("mismatched word changed the matrix");

  overlay_sel_a: assert property (
    clk_en |=> out_fill_sel == ~$past(ovl_s))
    else $error("overlay selection wrong");
endmodule
`default_nettype wire

//--- logic/xpc_sync.sv
`default_nettype none
module xpc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] d_out
);
  if (W < 1) begin : g_chk
    $error("xpc_sync: W must be at least 1");
  end

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // two stages, first stage read only by the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else if (clk_en) begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign d_out = sync_ff;
endmodule
`default_nettype wire
